// file: design/pcr_config_header.sv
// configuration header registers: identity, command/status, class, header, base address
`timescale 1ns/10ps
module pcr_config_header
    import pcr_pkg::*;
#(
    parameter logic [15:0] VENDOR_DEFAULT = 16'h1234,   // arbitrary value
    parameter logic [15:0] DEVICE_NO_SLAVE = 16'h0a10,  // arbitrary value
    parameter logic [15:0] DEVICE_EIGHT_SLAVE = 16'h0a18, // arbitrary value
    parameter logic [15:0] DEVICE_FOUR_SLAVE = 16'h0a14,  // arbitrary value
    parameter logic [7:0] SILICON_REV = 8'h01,           // arbitrary value
    parameter int EE_HALF = EE_HALF_CYC
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CFG_REQ,
    input wire logic CFG_WRITE,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_BE,
    input wire logic [31:0] CFG_WDATA,
    output logic [31:0] CFG_RDATA,
    output logic CFG_ACK,
    input wire logic [1:0] EXP_SLAVE_TYPE,
    input wire logic PARITY_ERR_EVENT,
    input wire logic SYSTEM_ERR_EVENT,
    input wire logic INTX_REQ,
    input wire logic MEM_REQ,
    input wire logic [31:0] MEM_ADDR,
    output logic INTX_ASSERT,
    output logic SERR_ASSERT,
    output logic PARITY_RESPONSE,
    output logic MEM_HIT,
    output logic IO_HIT,
    output logic EEPROM_SELECT,
    output logic EEPROM_SERIAL_CLOCK,
    output logic EEPROM_SERIAL_IN,
    input wire logic EEPROM_SERIAL_OUT,
    output logic EEPROM_LOAD_DONE
);
    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [1:0] exp_type;
    logic ee_out_sync;
    logic ee_valid;
    logic [1:0] ee_index;
    logic [15:0] ee_data;
    logic ee_done;
    logic ee_present;
    logic vendor_ovr;
    logic device_ovr;
    logic class_ovr;
    logic [15:0] vendor_ee;
    logic [15:0] device_ee;
    logic [23:0] class_ee;
    logic [15:0] device_strap;
    logic [31:0] id_word;
    logic [31:0] statcmd_word;
    logic [31:0] class_word;
    logic [31:0] bar_word;
    logic cmd_intx_dis;
    logic cmd_serr_en;
    logic cmd_perr_en;
    logic cmd_mem_en;
    logic sts_perr;
    logic sts_serr;
    logic [31:BAR_LSB] bar_base;
    logic wr_hit_statcmd;
    logic wr_hit_bar;
    logic [31:0] cmd_merged;
    logic [31:0] bar_merged;
    logic [31:0] next_rdata;
    logic intx_drive;
    logic serr_drive;
    logic perr_drive;
    logic mem_drive;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and eeprom master
    pcr_sync #(
        .WIDTH(2)
    ) u_strap_sync (
        .clock(CLOCK),
        .sys_rst(SYS_RST),
        .async_in(EXP_SLAVE_TYPE),
        .sync_out(exp_type)
    );

    pcr_sync #(
        .WIDTH(1)
    ) u_ee_sync (
        .clock(CLOCK),
        .sys_rst(SYS_RST),
        .async_in(EEPROM_SERIAL_OUT),
        .sync_out(ee_out_sync)
    );

    pcr_eeprom_loader #(
        .HALF_CYC(EE_HALF)
    ) u_loader (
        .clock(CLOCK),
        .sys_rst(SYS_RST),
        .serial_out(ee_out_sync),
        .select(EEPROM_SELECT),
        .serial_clock(EEPROM_SERIAL_CLOCK),
        .serial_in(EEPROM_SERIAL_IN),
        .word_valid(ee_valid),
        .word_index(ee_index),
        .word_data(ee_data),
        .load_done(ee_done)
    );

    assign EEPROM_LOAD_DONE = ee_done;

    ////////////////////////////////////////////////////////////////////////////
    // eeprom overrides
    // a blank or absent part reads all ones in the vendor word; the whole
    // image is then ignored so a missing eeprom keeps the built-in identity
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ee_present <= 1'b0;
        end else if (ee_valid && ee_index == EE_W_VENDOR) begin
            ee_present <= (ee_data != EE_BLANK);
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            vendor_ee <= 16'h0000;
            device_ee <= 16'h0000;
            class_ee <= 24'h000000;
        end else if (ee_valid) begin
            unique case (ee_index)
                EE_W_VENDOR: begin
                    vendor_ee <= ee_data;
                end
                EE_W_DEVICE: begin
                    device_ee <= ee_data;
                end
                EE_W_CLASS_HI: begin
                    class_ee[23:8] <= ee_data;
                end
                EE_W_CLASS_LO: begin
                    class_ee[7:0] <= ee_data[15:8];
                end
            endcase
        end
    end

    // overrides take effect only once the whole image has been read
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            vendor_ovr <= 1'b0;
            device_ovr <= 1'b0;
            class_ovr <= 1'b0;
        end else begin
            vendor_ovr <= ee_done && ee_present;
            device_ovr <= ee_done && ee_present;
            class_ovr <= ee_done && ee_present;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read-back words
    always_comb begin
        unique case (exp_type)
            EXP_EIGHT: device_strap = DEVICE_EIGHT_SLAVE;
            EXP_FOUR: device_strap = DEVICE_FOUR_SLAVE;
            default: device_strap = DEVICE_NO_SLAVE;
        endcase
    end

    assign id_word = {device_ovr ? device_ee : device_strap,
                      vendor_ovr ? vendor_ee : VENDOR_DEFAULT};
    assign class_word = {class_ovr ? class_ee : CLASS_DEFAULT,
                         SILICON_REV};

    always_comb begin
        statcmd_word = WORD_ZERO;
        statcmd_word[STS_PERR_BIT] = sts_perr;
        statcmd_word[STS_SERR_BIT] = sts_serr;
        statcmd_word[STS_CAPLIST_BIT] = 1'b1;
        statcmd_word[CMD_INTX_DIS_BIT] = cmd_intx_dis;
        statcmd_word[CMD_SERR_BIT] = cmd_serr_en;
        statcmd_word[CMD_PERR_BIT] = cmd_perr_en;
        statcmd_word[CMD_MEM_BIT] = cmd_mem_en;
        statcmd_word[CMD_IO_BIT] = 1'b0;
    end

    assign bar_word = {bar_base, {BAR_LSB{1'b0}}};

    ////////////////////////////////////////////////////////////////////////////
    // host writes
    assign wr_hit_statcmd = CFG_REQ && CFG_WRITE && (CFG_ADDR[7:2] == OFS_STATCMD[7:2]);
    assign wr_hit_bar = CFG_REQ && CFG_WRITE && (CFG_ADDR[7:2] == OFS_BAR[7:2]);
    assign cmd_merged = pcr_merge(statcmd_word, CFG_WDATA, CFG_BE);
    assign bar_merged = pcr_merge(bar_word, CFG_WDATA, CFG_BE);

    // only the four command flags and the base address store written data;
    // a one in status bit 30 or 31 with byte enable 3 set clears its flag, every other write falls on constant logic
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cmd_intx_dis <= 1'b0;
        end else if (wr_hit_statcmd) begin
            cmd_intx_dis <= cmd_merged[CMD_INTX_DIS_BIT];
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cmd_serr_en <= 1'b0;
        end else if (wr_hit_statcmd) begin
            cmd_serr_en <= cmd_merged[CMD_SERR_BIT];
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cmd_perr_en <= 1'b0;
        end else if (wr_hit_statcmd) begin
            cmd_perr_en <= cmd_merged[CMD_PERR_BIT];
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cmd_mem_en <= 1'b0;
        end else if (wr_hit_statcmd) begin
            cmd_mem_en <= cmd_merged[CMD_MEM_BIT];
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bar_base <= '0;
        end else if (wr_hit_bar) begin
            bar_base <= bar_merged[31:BAR_LSB];
        end
    end

    // sticky error flags: an event in the clearing cycle keeps the flag set
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sts_perr <= 1'b0;
        end else if (PARITY_ERR_EVENT) begin
            sts_perr <= 1'b1;
        end else if (wr_hit_statcmd && CFG_BE[BE_STATUS_HI] && CFG_WDATA[STS_PERR_BIT]) begin
            sts_perr <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sts_serr <= 1'b0;
        end else if (SYSTEM_ERR_EVENT) begin
            sts_serr <= 1'b1;
        end else if (wr_hit_statcmd && CFG_BE[BE_STATUS_HI] && CFG_WDATA[STS_SERR_BIT]) begin
            sts_serr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path, one-cycle answer
    always_comb begin
        unique case (CFG_ADDR[7:2])
            OFS_ID[7:2]: next_rdata = id_word;
            OFS_STATCMD[7:2]: next_rdata = statcmd_word;
            OFS_CLASS[7:2]: next_rdata = class_word;
            OFS_HDR[7:2]: next_rdata = HDR_WORD;
            OFS_BAR[7:2]: next_rdata = bar_word;
            default: next_rdata = WORD_ZERO;
        endcase
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            CFG_RDATA <= WORD_ZERO;
            CFG_ACK <= 1'b0;
        end else begin
            CFG_ACK <= CFG_REQ;
            if (CFG_REQ && !CFG_WRITE) begin
                CFG_RDATA <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control effects of the command flags
    assign intx_drive = INTX_REQ && !cmd_intx_dis;
    assign serr_drive = SYSTEM_ERR_EVENT && cmd_serr_en;
    assign perr_drive = PARITY_ERR_EVENT && cmd_perr_en;
    // the window claims 16k, so only the upper address bits take part
    assign mem_drive = MEM_REQ && cmd_mem_en
                       && (MEM_ADDR[31:BAR_LSB] == bar_base);

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            INTX_ASSERT <= 1'b0;
        end else begin
            INTX_ASSERT <= intx_drive;
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            SERR_ASSERT <= 1'b0;
        end else begin
            SERR_ASSERT <= serr_drive;
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PARITY_RESPONSE <= 1'b0;
        end else begin
            PARITY_RESPONSE <= perr_drive;
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            MEM_HIT <= 1'b0;
        end else begin
            MEM_HIT <= mem_drive;
        end
    end

    assign IO_HIT = 1'b0;
endmodule : pcr_config_header

// file: design/pcr_eeprom_loader.sv
// serial eeprom reader that fetches the identity override words after reset
`timescale 1ns/10ps
module pcr_eeprom_loader
    import pcr_pkg::*;
#(
    parameter int HALF_CYC = EE_HALF_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic serial_out,
    output logic select,
    output logic serial_clock,
    output logic serial_in,
    output logic word_valid,
    output logic [1:0] word_index,
    output logic [EE_WORD_W-1:0] word_data,
    output logic load_done
);
    pcr_ee_state_t state;
    logic [15:0] half_cnt;
    logic tick;
    logic [4:0] bit_num;
    logic [EE_WORD_W-1:0] shreg;

    // read frame: start bit, opcode, word address
    function automatic logic frame_bit(input logic [1:0] word, input logic [4:0] idx);
        logic [EE_CMD_BITS-1:0] frame;
        frame = {EE_OP_READ, {(EE_ADDR_W-2){1'b0}}, word};
        if (idx < 5'(EE_CMD_BITS)) begin
            return frame[4'(EE_CMD_BITS - 1) - idx[3:0]];
        end
        return 1'b0;
    endfunction : frame_bit

    assign tick = (half_cnt == 16'(HALF_CYC - 1));

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            half_cnt <= 16'h0000;
        end else if (tick) begin
            half_cnt <= 16'h0000;
        end else begin
            half_cnt <= half_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= EE_RESET;
            select <= 1'b0;
            serial_clock <= 1'b0;
            serial_in <= 1'b0;
            bit_num <= 5'h00;
            word_index <= 2'h0;
            shreg <= 16'h0000;
            word_valid <= 1'b0;
            word_data <= 16'h0000;
            load_done <= 1'b0;
        end else begin
            word_valid <= 1'b0;
            if (tick) begin
                unique case (state)
                    EE_RESET, EE_GAP: begin
                        if (state == EE_GAP && word_index == 2'(EE_WORDS - 1)) begin
                            state <= EE_DONE;
                            load_done <= 1'b1;
                        end else begin
                            if (state == EE_GAP) begin
                                word_index <= word_index + 2'h1;
                            end
                            state <= EE_SELECT;
                            select <= 1'b1;
                            bit_num <= 5'h00;
                            serial_in <= frame_bit(state == EE_GAP ? word_index + 2'h1
                                                                   : word_index, 5'h00);
                        end
                    end
                    EE_SELECT: begin
                        state <= EE_SHIFT;
                    end
                    EE_SHIFT: begin
                        if (!serial_clock) begin
                            serial_clock <= 1'b1;
                        end else begin
                            // eeprom drives on the rise, so sample on the fall
                            serial_clock <= 1'b0;
                            if (bit_num >= EE_FIRST_DATA) begin
                                shreg <= {shreg[EE_WORD_W-2:0], serial_out};
                            end
                            if (bit_num == EE_LAST_BIT) begin
                                select <= 1'b0;
                                serial_in <= 1'b0;
                                word_valid <= 1'b1;
                                word_data <= {shreg[EE_WORD_W-2:0], serial_out};
                                state <= EE_GAP;
                            end else begin
                                bit_num <= bit_num + 5'h01;
                                serial_in <= frame_bit(word_index, bit_num + 5'h01);
                            end
                        end
                    end
                    EE_DONE: begin
                        state <= EE_DONE;
                    end
                endcase
            end
        end
    end
endmodule : pcr_eeprom_loader

// file: design/pcr_pkg.sv
// constants, state codes and helpers for the configuration header block
package pcr_pkg;
    localparam int unsigned CLK_PERIOD_NS = 8;
    // eeprom serial clock half period, least time
    localparam int unsigned EE_HALF_NS = 500;
    localparam int unsigned EE_HALF_CYC = (EE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0] OFS_ID = 8'h00;
    localparam logic [7:0] OFS_STATCMD = 8'h04;
    localparam logic [7:0] OFS_CLASS = 8'h08;
    localparam logic [7:0] OFS_HDR = 8'h0c;
    localparam logic [7:0] OFS_BAR = 8'h10;

    localparam int CMD_IO_BIT = 0;
    localparam int CMD_MEM_BIT = 1;
    localparam int CMD_PERR_BIT = 6;
    localparam int CMD_SERR_BIT = 8;
    localparam int CMD_INTX_DIS_BIT = 10;
    localparam int STS_CAPLIST_BIT = 20;
    localparam int STS_SERR_BIT = 30;
    localparam int STS_PERR_BIT = 31;
    localparam int BAR_LSB = 14;
    localparam int BE_STATUS_HI = 3;

    localparam logic [23:0] CLASS_DEFAULT = 24'h070002;
    localparam logic [31:0] HDR_WORD = 32'h00000000;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;

    localparam logic [1:0] EXP_NONE = 2'h0;
    localparam logic [1:0] EXP_EIGHT = 2'h1;
    localparam logic [1:0] EXP_FOUR = 2'h2;

    localparam int EE_ADDR_W = 6;
    localparam int EE_WORD_W = 16;
    localparam int EE_CMD_BITS = 9;
    localparam logic [2:0] EE_OP_READ = 3'h6;
    localparam logic [4:0] EE_FIRST_DATA = 5'h09;
    localparam logic [4:0] EE_LAST_BIT = 5'h18;
    localparam int EE_WORDS = 4;
    localparam logic [1:0] EE_W_VENDOR = 2'h0;
    localparam logic [1:0] EE_W_DEVICE = 2'h1;
    localparam logic [1:0] EE_W_CLASS_HI = 2'h2;
    localparam logic [1:0] EE_W_CLASS_LO = 2'h3;
    localparam logic [15:0] EE_BLANK = 16'hffff;

    typedef enum logic [4:0] {
        EE_RESET = 5'h01,
        EE_SELECT = 5'h02,
        EE_SHIFT = 5'h04,
        EE_GAP = 5'h08,
        EE_DONE = 5'h10
    } pcr_ee_state_t;

    // byte-lane merge of a host write into a stored word
    function automatic logic [31:0] pcr_merge(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0] be);
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction : pcr_merge
endpackage : pcr_pkg

// file: design/pcr_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module pcr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : pcr_sync

// file: sim/pcr_config_header_assertions.sv
// concurrent checks on the configuration header ports
`timescale 1ns/10ps
module pcr_config_header_assertions (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CFG_REQ,
    input wire logic CFG_WRITE,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_BE,
    input wire logic [31:0] CFG_WDATA,
    input wire logic [31:0] CFG_RDATA,
    input wire logic INTX_REQ,
    input wire logic SYSTEM_ERR_EVENT,
    input wire logic PARITY_ERR_EVENT,
    input wire logic MEM_REQ,
    input wire logic INTX_ASSERT,
    input wire logic SERR_ASSERT,
    input wire logic PARITY_RESPONSE,
    input wire logic MEM_HIT,
    input wire logic IO_HIT,
    input wire logic EEPROM_SELECT,
    input wire logic EEPROM_SERIAL_CLOCK,
    input wire logic EEPROM_LOAD_DONE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////////
    // shadow of command bits 10,8,6,1 taken from host writes
    logic [3:0] cmd;
    wire wr_cmd = CFG_REQ && CFG_WRITE && CFG_ADDR[7:2] == 6'h01;
    wire rd_sts = CFG_REQ && !CFG_WRITE && CFG_ADDR[7:2] == 6'h01;
    wire rd_hdr = CFG_REQ && !CFG_WRITE && CFG_ADDR[7:2] == 6'h03;
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cmd <= 4'h0;
        end else if (wr_cmd) begin
            if (CFG_BE[0]) cmd[1:0] <= {CFG_WDATA[6], CFG_WDATA[1]};
            if (CFG_BE[1]) cmd[3:2] <= {CFG_WDATA[10], CFG_WDATA[8]};
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_io; !IO_HIT; endproperty
    a_io: assert property (p_io)
        else $error("io decode hit");
    property p_hdr; rd_hdr |=> CFG_RDATA == 32'h0; endproperty
    a_hdr: assert property (p_hdr)
        else $error("header word not zero");
    property p_sts; rd_sts |=> (CFG_RDATA & 32'h3ffffabd) == 32'h00100000; endproperty
    a_sts: assert property (p_sts)
        else $error("fixed status or command bits wrong");
    property p_intx; INTX_REQ |=> INTX_ASSERT == !$past(cmd[3]); endproperty
    a_intx: assert property (p_intx)
        else $error("interrupt gating wrong");
    property p_serr; 1'b1 |=> SERR_ASSERT == ($past(SYSTEM_ERR_EVENT) && $past(cmd[2]));
    endproperty
    a_serr: assert property (p_serr)
        else $error("error driver gating wrong");
    property p_par; 1'b1 |=> PARITY_RESPONSE == ($past(PARITY_ERR_EVENT) && $past(cmd[1]));
    endproperty
    a_par: assert property (p_par)
        else $error("parity response gating wrong");
    property p_mem; MEM_REQ && !cmd[0] |=> !MEM_HIT; endproperty
    a_mem: assert property (p_mem)
        else $error("memory hit while disabled");
    property p_done; EEPROM_LOAD_DONE |=> EEPROM_LOAD_DONE; endproperty
    a_done: assert property (p_done)
        else $error("load done dropped");
    property p_sck; !EEPROM_SELECT |-> !EEPROM_SERIAL_CLOCK; endproperty
    a_sck: assert property (p_sck)
        else $error("serial clock outside frame");
endmodule : pcr_config_header_assertions

bind pcr_config_header pcr_config_header_assertions u_pcr_config_header_assertions (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .CFG_REQ(CFG_REQ), .CFG_WRITE(CFG_WRITE),
    .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
    .INTX_REQ(INTX_REQ), .SYSTEM_ERR_EVENT(SYSTEM_ERR_EVENT), .MEM_REQ(MEM_REQ),
    .PARITY_ERR_EVENT(PARITY_ERR_EVENT), .INTX_ASSERT(INTX_ASSERT), .SERR_ASSERT(SERR_ASSERT),
    .PARITY_RESPONSE(PARITY_RESPONSE), .MEM_HIT(MEM_HIT), .IO_HIT(IO_HIT),
    .EEPROM_SELECT(EEPROM_SELECT), .EEPROM_SERIAL_CLOCK(EEPROM_SERIAL_CLOCK),
    .EEPROM_LOAD_DONE(EEPROM_LOAD_DONE)
);

// file: sim/pcr_eeprom_model.sv
// behavioural serial eeprom answering the identity word reads
`timescale 1ns/10ps
module pcr_eeprom_model #(
    parameter logic [15:0] WORD0 = 16'h0000,
    parameter logic [15:0] WORD1 = 16'h0000,
    parameter logic [15:0] WORD2 = 16'h0000,
    parameter logic [15:0] WORD3 = 16'h0000
) (
    input wire logic select,
    input wire logic serial_clock,
    input wire logic serial_in,
    output logic serial_out
);
    logic [15:0] mem [4];
    logic [8:0] cmd;
    int n;
    initial begin
        mem = '{WORD0, WORD1, WORD2, WORD3};
        serial_out = 1'b0;
        n = 0;
    end
    always @(posedge select) n = 0;
    // released line must not hold a stale bit
    always @(negedge select) serial_out <= ~serial_out;
    always @(posedge serial_clock) begin
        if (select) begin
            if (n < 9) begin
                cmd = {cmd[7:0], serial_in};
            end else if (n < 25) begin
                // bad opcode gets garbage, as a real part would
                serial_out <= (cmd[8:2] == 7'h60) ? mem[cmd[1:0]][24 - n] : ~serial_out;
            end
            n = n + 1;
        end
    end
endmodule : pcr_eeprom_model

// file: sim/tb_pcr_config_header.sv
// self-checking bench for the configuration header registers
`timescale 1ns/10ps
module tb_pcr_config_header;
    import pcr_pkg::*;
    localparam logic [15:0] VEN = 16'h1234; // arbitrary value
    localparam logic [7:0] REV = 8'h01; // arbitrary value
    localparam logic [3:0][15:0] DEV = {16'h0a10, 16'h0a14, 16'h0a18, 16'h0a10}; // arbitrary
    localparam logic [3:0][15:0] EW = {16'h2000, 16'h0c03, 16'hcafe, 16'hbeef};
    logic clock, sys_rst, req, wr, ack, perr, serr_ev, intx_req, mem_req;
    logic intx, serr, pres, mem_hit, io_hit, ee_cs, ee_sk, ee_di, ee_do, done;
    logic [7:0] addr;
    logic [3:0] be;
    logic [1:0] slave;
    logic [31:0] wdata, rdata, mem_addr;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    pcr_config_header #(.VENDOR_DEFAULT(VEN), .DEVICE_NO_SLAVE(DEV[0]),
        .DEVICE_EIGHT_SLAVE(DEV[1]), .DEVICE_FOUR_SLAVE(DEV[2]), .SILICON_REV(REV),
        .EE_HALF(4)) u_pcr_config_header (
        .CLOCK(clock), .SYS_RST(sys_rst), .CFG_REQ(req), .CFG_WRITE(wr), .CFG_ADDR(addr),
        .CFG_BE(be), .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_ACK(ack),
        .EXP_SLAVE_TYPE(slave), .PARITY_ERR_EVENT(perr), .SYSTEM_ERR_EVENT(serr_ev),
        .INTX_REQ(intx_req), .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .INTX_ASSERT(intx),
        .SERR_ASSERT(serr), .PARITY_RESPONSE(pres), .MEM_HIT(mem_hit), .IO_HIT(io_hit),
        .EEPROM_SELECT(ee_cs), .EEPROM_SERIAL_CLOCK(ee_sk), .EEPROM_SERIAL_IN(ee_di),
        .EEPROM_SERIAL_OUT(ee_do), .EEPROM_LOAD_DONE(done));
    pcr_eeprom_model #(.WORD0(EW[0]), .WORD1(EW[1]), .WORD2(EW[2]), .WORD3(EW[3]))
        u_pcr_eeprom_model (.select(ee_cs), .serial_clock(ee_sk), .serial_in(ee_di),
        .serial_out(ee_do));
    ////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic step();
        @(posedge clock);
        #1;
    endtask : step
    // leaves the request up so accesses can run back to back
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] d);
        req = 1'b1;
        wr = w;
        addr = a;
        be = b;
        wdata = d;
        step();
        chk("ack", {31'h0, ack}, 32'h1);
    endtask : acc
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        acc(1'b0, a, 4'h0, 32'h0);
        chk(nm, rdata, exp);
    endtask : rdc
    task automatic pulse_chk(input logic [3:0] exp);
        req = 1'b0;
        mem_req = 1'b1;
        perr = 1'b1;
        serr_ev = 1'b1;
        step();
        mem_req = 1'b0;
        perr = 1'b0;
        serr_ev = 1'b0;
        chk("gated outputs", {28'h0, intx, serr, pres, mem_hit}, {28'h0, exp});
    endtask : pulse_chk
    ////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        {req, wr, perr, serr_ev, mem_req, addr, be, wdata, slave} = '0;
        intx_req = 1'b1;
        mem_addr = 32'hffffc010;
        sys_rst = 1'b1;
        repeat (3) @(posedge clock);
        #1 sys_rst = 1'b0;
        rdc(OFS_STATCMD, 32'h00100000, "status");
        rdc(OFS_HDR, WORD_ZERO, "header");
        rdc(OFS_CLASS, {CLASS_DEFAULT, REV}, "class");
        rdc(OFS_BAR, WORD_ZERO, "bar");
        rdc(8'h14, WORD_ZERO, "unmapped");
        for (int i = 0; i < 4; i++) begin
            req = 1'b0;
            slave = i[1:0];
            repeat (4) step();
            rdc(OFS_ID, {DEV[i], VEN}, "ident");
        end
        $display("test defaults done");
        acc(1'b1, OFS_STATCMD, 4'hf, 32'hffffffff);
        acc(1'b1, OFS_ID, 4'hf, 32'h0);
        acc(1'b1, OFS_CLASS, 4'hf, 32'h0);
        acc(1'b1, OFS_HDR, 4'hf, 32'hffffffff);
        acc(1'b1, OFS_BAR, 4'hf, 32'hffffffff);
        rdc(OFS_STATCMD, 32'h00100542, "cmd");
        rdc(OFS_ID, {DEV[3], VEN}, "ident ro");
        rdc(OFS_CLASS, {CLASS_DEFAULT, REV}, "class ro");
        rdc(OFS_HDR, WORD_ZERO, "header ro");
        rdc(OFS_BAR, 32'hffffc000, "bar");
        $display("test writes done");
        pulse_chk(4'b0111);
        rdc(OFS_STATCMD, 32'hc0100542, "flags set");
        acc(1'b1, OFS_STATCMD, 4'h8, 32'h80000000);
        rdc(OFS_STATCMD, 32'h40100542, "parity clear");
        acc(1'b1, OFS_STATCMD, 4'h7, 32'h40000000);
        rdc(OFS_STATCMD, 32'h40100000, "no lane clear");
        acc(1'b1, OFS_STATCMD, 4'h8, 32'h40000000);
        rdc(OFS_STATCMD, 32'h00100000, "system clear");
        pulse_chk(4'b1000);
        rdc(OFS_STATCMD, 32'hc0100000, "flags again");
        sys_rst = 1'b1;
        step();
        sys_rst = 1'b0;
        rdc(OFS_STATCMD, 32'h00100000, "reset again");
        $display("test command status done");
        req = 1'b0;
        for (int i = 0; i < 3000 && done !== 1'b1; i++) step();
        repeat (2) step();
        chk("load done", {31'h0, done}, 32'h1);
        rdc(OFS_ID, {EW[1], EW[0]}, "ident loaded");
        rdc(OFS_CLASS, {EW[2], EW[3][15:8], REV}, "class loaded");
        $display("test eeprom load done");
        end_sim();
    end
endmodule : tb_pcr_config_header
